// ---- shared/supervisor_pkg.sv ----
// constants, scalings and enumerations shared by the converter supervisor
package supervisor_pkg;

	// ==================== clock and timing ====================
	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned TICK_US           = 20;
	localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned OPEN_LOOP_US      = 1000;
	localparam int unsigned OPEN_LOOP_TICKS   = OPEN_LOOP_US / TICK_US;
	localparam int unsigned RETRY_MS          = 2000;
	localparam int unsigned RETRY_TICKS       = RETRY_MS * 1000 / TICK_US;
	localparam int unsigned CURLIM_MS         = 2000;
	localparam int unsigned CURLIM_TICKS      = CURLIM_MS * 1000 / TICK_US;

	// ==================== sample scaling ====================
	// voltages in 10 mV units, currents in 10 mA units, temperature in whole degrees, power in watts
	localparam int unsigned SAMPLE_W          = 16;
	localparam int unsigned POWER_W           = 32;
	localparam logic [15:0] VOUT_OV_DEFAULT   = 16'h1838;  // 62.00 V
	localparam logic [15:0] VIN_MIN           = 16'h86c4;  // 345.00 V
	localparam logic [15:0] VIN_MAX           = 16'ha21c;  // 415.00 V
	localparam logic [31:0] POWER_MAX_W       = 32'h00000c80;  // 3200 W
	localparam logic [15:0] BURST_SOFT_OV     = 16'h004b;  // 0.75 V above target
	localparam logic [15:0] BURST_HARD_OV     = 16'h00fa;  // 2.50 V above target
	localparam logic [15:0] FAN_ON_DEG        = 16'h002d;  // 45
	localparam logic [15:0] FAN_OFF_DEG       = 16'h0023;  // 35
	localparam logic [15:0] OVER_TEMP_DEG     = 16'h0050;  // 80
	localparam logic [15:0] RECT_IOUT_MIN     = 16'h01c2;  // 4.50 A
	localparam logic [15:0] RECT_IRES_MAX     = 16'h0384;  // 9.00 A
	localparam logic [15:0] RECT_VOUT_MIN     = 16'h10cc;  // 43.00 V
	localparam logic [15:0] RECT_DLOAD_MAX    = 16'h0320;  // 8.00 A

	// ==================== rectifier on-time ramp ====================
	localparam int unsigned ONTIME_W          = 10;
	localparam logic [9:0]  ONTIME_START      = 10'h010;
	localparam logic [9:0]  ONTIME_STEP       = 10'h008;
	localparam logic [9:0]  ONTIME_FULL       = 10'h3ff;

	// ==================== dead time ====================
	localparam int unsigned DT_W              = 12;
	localparam int unsigned DT_SHIFT          = 16;

	// ==================== fault flag positions ====================
	localparam int unsigned FAULT_W           = 5;
	localparam int unsigned F_OUT_OV          = 0;
	localparam int unsigned F_IN_RANGE        = 1;
	localparam int unsigned F_OVER_POWER      = 2;
	localparam int unsigned F_OPEN_LOOP       = 3;
	localparam int unsigned F_OVER_TEMP       = 4;

	// ==================== loop gains ====================
	typedef enum logic [1:0] {CAP_4MF, CAP_6MF, CAP_8MF} cap_sel_e;
	localparam int unsigned GAIN_W            = 16;
	localparam logic [15:0] KP_4MF            = 16'h0100;
	localparam logic [15:0] KI_4MF            = 16'h0010;
	localparam logic [15:0] KP_6MF            = 16'h0180;
	localparam logic [15:0] KI_6MF            = 16'h0018;
	localparam logic [15:0] KP_8MF            = 16'h0200;
	localparam logic [15:0] KI_8MF            = 16'h0020;

	typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_BURST, ST_WAIT} run_state_e;

endpackage

// ---- hw/sync_rectifier_ctl.sv ----
// per-phase synchronous rectifier gate and on-time ramp
`timescale 1ns/1ns
module sync_rectifier_ctl
	import supervisor_pkg::*;
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       tick,
	// phase measurements
	input  wire logic [SAMPLE_W-1:0]        iout,
	input  wire logic [SAMPLE_W-1:0]        ires,
	input  wire logic [SAMPLE_W-1:0]        vout,
	input  wire logic [SAMPLE_W-1:0]        dload,
	input  wire logic                       load_jump,
	input  wire logic                       force_off,
	// rectifier drive
	output logic                            enable,
	output logic [supervisor_pkg::ONTIME_W-1:0] on_time
);
	logic                 en_reg;
	logic                 en_next;
	logic [ONTIME_W-1:0]  ot_reg;
	logic [ONTIME_W-1:0]  ot_next;
	wire                  allow;
	wire                  at_full;

	assign allow   = (iout > RECT_IOUT_MIN) && (ires < RECT_IRES_MAX) &&
	                 (vout > RECT_VOUT_MIN) && (dload < RECT_DLOAD_MAX);
	assign at_full = (ot_reg >= ONTIME_FULL - ONTIME_STEP);

	always_comb begin
		en_next = en_reg;
		ot_next = ot_reg;
		if (force_off || load_jump || !allow) begin
			en_next = 1'b0;
			ot_next = '0;
		end else if (tick) begin
			en_next = 1'b1;
			if (!en_reg)
				ot_next = ONTIME_START;
			else if (at_full)
				ot_next = ONTIME_FULL;
			else
				ot_next = ot_reg + ONTIME_STEP;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_reg <= 1'b0;
			ot_reg <= '0;
		end else begin
			en_reg <= en_next;
			ot_reg <= ot_next;
		end
	end

	assign enable  = en_reg;
	assign on_time = ot_reg;
endmodule

// ---- hw/dead_time_unit.sv ----
// per-phase dead-time computation with shadow and active registers
`timescale 1ns/1ns
module dead_time_unit
	import supervisor_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    tick,
	// inputs
	input  wire logic [SAMPLE_W-1:0]     fsw_khz,
	input  wire logic [SAMPLE_W-1:0]     slope,
	input  wire logic [DT_W-1:0]         dead_time_trim,
	input  wire logic                    period_end,
	// outputs
	output logic [supervisor_pkg::DT_W-1:0] dead_time
);
	logic [DT_W-1:0]   shadow_reg;
	logic              pending_reg;
	logic [DT_W-1:0]   active_reg;
	wire  [31:0]       prod;
	wire  [DT_W-1:0]   dt_calc;

	// dead time = trim + (slope * fsw) / 65536, slope already holding the Coss*Lm constant
	assign prod    = fsw_khz * slope;
	assign dt_calc = dead_time_trim + prod[DT_SHIFT +: DT_W];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_reg  <= '0;
			pending_reg <= 1'b0;
			active_reg  <= '0;
		end else begin
			if (tick) begin
				shadow_reg  <= dt_calc;
				pending_reg <= 1'b1;
			end else if (period_end && pending_reg) begin
				active_reg  <= shadow_reg;
				pending_reg <= 1'b0;
			end
		end
	end

	assign dead_time = active_reg;
endmodule

// ---- hw/converter_protection_supervisor.sv ----
// protection, fan, burst, rectifier, dead-time and gain supervisor for a dual-phase converter
// ====================
`timescale 1ns/1ns
module converter_protection_supervisor
	import supervisor_pkg::*;
#(
	parameter int unsigned RETRY_CYCLES_TICKS  = RETRY_TICKS,
	parameter int unsigned CURLIM_CYCLES_TICKS = CURLIM_TICKS,
	parameter int unsigned TICK_LEN            = TICK_CYCLES
)(
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               rst_n,
	// configuration
	input  wire logic                               run_request,
	input  wire logic                               latching_mode,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] vout_ov_limit,
	input  wire logic [supervisor_pkg::DT_W-1:0]     dead_time_trim,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] dt_slope,
	input  wire supervisor_pkg::cap_sel_e            cap_sel,
	input  wire logic                               fault_clear,
	// filtered samples
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] vin,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] vout,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] vout_target,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] iout_1,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] iout_2,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] ires_1,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] ires_2,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] dload_1,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] dload_2,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] temp_1,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] temp_2,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] fsw_khz_1,
	input  wire logic [supervisor_pkg::SAMPLE_W-1:0] fsw_khz_2,
	// power stage status
	input  wire logic                               at_min_freq_1,
	input  wire logic                               at_min_freq_2,
	input  wire logic                               at_max_freq,
	input  wire logic                               current_limiting,
	input  wire logic                               load_jump_1,
	input  wire logic                               load_jump_2,
	input  wire logic                               period_end_1,
	input  wire logic                               period_end_2,
	// converter control
	output logic                                    converter_on,
	output logic                                    start_sequence,
	output logic                                    burst_active,
	output logic                                    fan_on,
	output logic [supervisor_pkg::FAULT_W-1:0]      fault_flags,
	output logic                                    sample_tick,
	// rectifiers
	output logic                                    sync_rectifier_en_1,
	output logic                                    sync_rectifier_en_2,
	output logic [supervisor_pkg::ONTIME_W-1:0]     sync_rectifier_on_time_1,
	output logic [supervisor_pkg::ONTIME_W-1:0]     sync_rectifier_on_time_2,
	// high resolution pulse unit
	output logic [supervisor_pkg::DT_W-1:0]         high_res_pulse_unit_dt_1,
	output logic [supervisor_pkg::DT_W-1:0]         high_res_pulse_unit_dt_2,
	// loop gains
	output logic [supervisor_pkg::GAIN_W-1:0]       loop_kp,
	output logic [supervisor_pkg::GAIN_W-1:0]       loop_ki
);
	import supervisor_pkg::*;

	if (TICK_LEN < 2 || RETRY_CYCLES_TICKS < 1 || CURLIM_CYCLES_TICKS < 1) begin : bad_timing
		$error("supervisor: timing parameters out of range");
	end

	// ==================== reset synchroniser ====================
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire rstn_i = rst_sync_reg;

	// ==================== sample tick ====================
	logic [31:0] tick_cnt_reg;
	wire         tick = (tick_cnt_reg == TICK_LEN - 1);
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
	end

	// ==================== threshold comparisons ====================
	wire [POWER_W-1:0] p1      = (iout_1 * vout) / 32'd10000;
	wire [POWER_W-1:0] p2      = (iout_2 * vout) / 32'd10000;
	wire [POWER_W-1:0] p_total = p1 + p2;
	wire [SAMPLE_W:0]  ov_amt  = {1'b0, vout} - {1'b0, vout_target};
	wire               above_t = (vout > vout_target);
	wire               ov_soft = above_t && (ov_amt[SAMPLE_W-1:0] > BURST_SOFT_OV);
	wire               ov_hard = above_t && (ov_amt[SAMPLE_W-1:0] > BURST_HARD_OV);
	wire               out_ov  = vout > vout_ov_limit;
	wire               in_bad  = (vin < VIN_MIN) || (vin > VIN_MAX);
	wire               pw_bad  = p_total > POWER_MAX_W;
	wire [SAMPLE_W-1:0] t_max  = (temp_1 > temp_2) ? temp_1 : temp_2;
	wire               hot     = t_max > OVER_TEMP_DEG;

	// ==================== timers ====================
	logic [31:0] openloop_cnt_reg;
	logic [31:0] curlim_cnt_reg;
	logic [31:0] retry_cnt_reg;
	wire         both_min  = at_min_freq_1 && at_min_freq_2;
	wire         open_loop = (openloop_cnt_reg >= OPEN_LOOP_TICKS);
	wire         curlim_to = (curlim_cnt_reg >= CURLIM_CYCLES_TICKS);
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i) begin
			openloop_cnt_reg <= '0;
			curlim_cnt_reg   <= '0;
		end else if (tick) begin
			openloop_cnt_reg <= (both_min && converter_on) ? openloop_cnt_reg + 32'h1 : '0;
			curlim_cnt_reg   <= (current_limiting && converter_on) ? curlim_cnt_reg + 32'h1 : '0;
		end
	end

	// ==================== fault flags ====================
	logic [FAULT_W-1:0] flags_reg;
	logic [FAULT_W-1:0] flags_next;
	logic [FAULT_W-1:0] set_vec;
	always_comb begin
		set_vec = '0;
		if (tick) begin
			set_vec[F_OUT_OV]     = out_ov;
			set_vec[F_IN_RANGE]   = in_bad;
			set_vec[F_OVER_POWER] = pw_bad || curlim_to;
			set_vec[F_OPEN_LOOP]  = open_loop;
			set_vec[F_OVER_TEMP]  = hot;
		end
		// over-temperature survives the software clear; set wins over clear
		flags_next = fault_clear ? (flags_reg & (FAULT_W'(1) << F_OVER_TEMP)) : flags_reg;
		flags_next = flags_next | set_vec;
	end
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

	// latched shutdown: over-temperature always, output over-voltage, over-power and open loop only in latching mode
	logic temp_lock_reg;
	logic fault_lock_reg;
	wire  trip = set_vec[F_OUT_OV] | set_vec[F_OVER_POWER] | set_vec[F_OPEN_LOOP];
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i) begin
			temp_lock_reg  <= 1'b0;
			fault_lock_reg <= 1'b0;
		end else begin
			if (set_vec[F_OVER_TEMP])
				temp_lock_reg <= 1'b1;
			if (trip && latching_mode)
				fault_lock_reg <= 1'b1;
			else if (fault_clear)
				fault_lock_reg <= 1'b0;
		end
	end

	// ==================== run state machine ====================
	run_state_e state_reg;
	run_state_e state_next;
	logic [31:0] retry_next;
	wire  blocked = temp_lock_reg || fault_lock_reg || in_bad || !run_request;
	always_comb begin
		state_next = state_reg;
		retry_next = retry_cnt_reg;
		case (state_reg)
			ST_OFF: begin
				if (!blocked && tick)
					state_next = ST_RUN;
			end
			ST_RUN: begin
				if (blocked)
					state_next = ST_OFF;
				else if (trip) begin
					state_next = ST_WAIT;
					retry_next = '0;
				end else if (tick && (ov_hard || (ov_soft && at_max_freq)))
					state_next = ST_BURST;
			end
			ST_BURST: begin
				if (blocked)
					state_next = ST_OFF;
				else if (tick && !above_t)
					state_next = ST_RUN;
			end
			ST_WAIT: begin
				if (temp_lock_reg || fault_lock_reg)
					state_next = ST_OFF;
				else if (tick) begin
					retry_next = retry_cnt_reg + 32'h1;
					if (retry_cnt_reg >= RETRY_CYCLES_TICKS - 1)
						state_next = ST_OFF;
				end
			end
			default: state_next = ST_OFF;
		endcase
	end

	logic on_reg;
	logic start_reg;
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg     <= ST_OFF;
			retry_cnt_reg <= '0;
			on_reg        <= 1'b0;
			start_reg     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			retry_cnt_reg <= retry_next;
			on_reg        <= (state_next == ST_RUN);
			start_reg     <= (state_next == ST_RUN) && (state_reg != ST_RUN);
		end
	end

	// ==================== fan hysteresis ====================
	logic fan_reg;
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i)
			fan_reg <= 1'b0;
		else if (tick) begin
			if (t_max > FAN_ON_DEG)
				fan_reg <= 1'b1;
			else if (t_max < FAN_OFF_DEG)
				fan_reg <= 1'b0;
		end
	end

	// ==================== gain selection ====================
	logic [GAIN_W-1:0] kp_reg;
	logic [GAIN_W-1:0] ki_reg;
	wire  [GAIN_W-1:0] kp_sel = (cap_sel == CAP_8MF) ? KP_8MF : (cap_sel == CAP_6MF) ? KP_6MF : KP_4MF;
	wire  [GAIN_W-1:0] ki_sel = (cap_sel == CAP_8MF) ? KI_8MF : (cap_sel == CAP_6MF) ? KI_6MF : KI_4MF;
	always_ff @(posedge ref_clk or negedge rstn_i) begin
		if (!rstn_i) begin
			kp_reg <= KP_4MF;
			ki_reg <= KI_4MF;
		end else if (state_reg == ST_OFF) begin
			kp_reg <= kp_sel;
			ki_reg <= ki_sel;
		end
	end

	// ==================== per-phase units ====================
	wire rect_off = (state_reg != ST_RUN);
	sync_rectifier_ctl u_rect_1 (
		.clk       (ref_clk),
		.rst_n     (rstn_i),
		.tick      (tick),
		.iout      (iout_1),
		.ires      (ires_1),
		.vout      (vout),
		.dload     (dload_1),
		.load_jump (load_jump_1),
		.force_off (rect_off),
		.enable    (sync_rectifier_en_1),
		.on_time   (sync_rectifier_on_time_1)
	);
	sync_rectifier_ctl u_rect_2 (
		.clk       (ref_clk),
		.rst_n     (rstn_i),
		.tick      (tick),
		.iout      (iout_2),
		.ires      (ires_2),
		.vout      (vout),
		.dload     (dload_2),
		.load_jump (load_jump_2),
		.force_off (rect_off),
		.enable    (sync_rectifier_en_2),
		.on_time   (sync_rectifier_on_time_2)
	);
	dead_time_unit u_dt_1 (
		.clk            (ref_clk),
		.rst_n          (rstn_i),
		.tick           (tick),
		.fsw_khz        (fsw_khz_1),
		.slope          (dt_slope),
		.dead_time_trim (dead_time_trim),
		.period_end     (period_end_1),
		.dead_time      (high_res_pulse_unit_dt_1)
	);
	dead_time_unit u_dt_2 (
		.clk            (ref_clk),
		.rst_n          (rstn_i),
		.tick           (tick),
		.fsw_khz        (fsw_khz_2),
		.slope          (dt_slope),
		.dead_time_trim (dead_time_trim),
		.period_end     (period_end_2),
		.dead_time      (high_res_pulse_unit_dt_2)
	);

	// ==================== outputs ====================
	assign converter_on   = on_reg;
	assign start_sequence = start_reg;
	assign burst_active   = (state_reg == ST_BURST);
	assign fan_on         = fan_reg;
	assign fault_flags    = flags_reg;
	assign sample_tick    = tick;
	assign loop_kp        = kp_reg;
	assign loop_ki        = ki_reg;
endmodule

// ---- bench/supervisor_monitor.sv ----
// assertion checker for the converter supervisor
`timescale 1ns/1ns
module supervisor_monitor
	import supervisor_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        at_max_freq,
	input wire logic        load_jump_1,
	input wire logic        period_end_1,
	input wire logic        sample_tick,
	input wire logic        converter_on,
	input wire logic        start_sequence,
	input wire logic        burst_active,
	input wire logic        fan_on,
	input wire logic        sync_rectifier_en_1,
	input wire logic [15:0] vin,
	input wire logic [15:0] vout,
	input wire logic [15:0] vout_target,
	input wire logic [15:0] vout_ov_limit,
	input wire logic [15:0] iout_1,
	input wire logic [15:0] ires_1,
	input wire logic [15:0] dload_1,
	input wire logic [15:0] temp_1,
	input wire logic [15:0] temp_2,
	input wire logic [4:0]  fault_flags,
	input wire logic [9:0]  sync_rectifier_on_time_1,
	input wire logic [11:0] high_res_pulse_unit_dt_1,
	input wire logic [15:0] loop_kp
);
	import supervisor_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==================== faults ====================
	ov_off_a: assert property (sample_tick && converter_on && vout > vout_ov_limit
		|=> fault_flags[F_OUT_OV] ##1 !converter_on) else $error("ov trip missing");
	vin_window_a: assert property ($rose(converter_on)
		|-> $past(vin) >= VIN_MIN && $past(vin) <= VIN_MAX) else $error("start outside vin window");
	start_pulse_a: assert property (start_sequence == $rose(converter_on))
		else $error("start sequence pulse wrong");
	temp_latch_a: assert property (fault_flags[F_OVER_TEMP]
		|=> fault_flags[F_OVER_TEMP] && !converter_on) else $error("overtemp not held");
	// ==================== fan and burst ====================
	fan_on_a: assert property (sample_tick && (temp_1 > FAN_ON_DEG || temp_2 > FAN_ON_DEG) |=> fan_on)
		else $error("fan not on");
	fan_off_a: assert property (sample_tick && temp_1 < FAN_OFF_DEG && temp_2 < FAN_OFF_DEG |=> !fan_on)
		else $error("fan not off");
	burst_hard_a: assert property (sample_tick && converter_on && !burst_active && vout <= vout_ov_limit
		&& vout > vout_target + BURST_HARD_OV |=> burst_active) else $error("hard burst missing");
	burst_soft_a: assert property (sample_tick && converter_on && !burst_active && !at_max_freq
		&& vout <= vout_target + BURST_HARD_OV |=> !burst_active) else $error("burst below max freq");
	// ==================== rectifier, dead time, gains ====================
	rect_off_a: assert property (burst_active || load_jump_1 |=> !sync_rectifier_en_1)
		else $error("rectifier left on");
	rect_start_a: assert property ($rose(sync_rectifier_en_1) |-> $past(sample_tick)
		&& sync_rectifier_on_time_1 == ONTIME_START && $past(iout_1) > RECT_IOUT_MIN
		&& $past(ires_1) < RECT_IRES_MAX && $past(vout) > RECT_VOUT_MIN && $past(dload_1) < RECT_DLOAD_MAX)
		else $error("rectifier start wrong");
	dt_hold_a: assert property (!period_end_1 |=> $stable(high_res_pulse_unit_dt_1))
		else $error("dead time moved off period end");
	gain_hold_a: assert property (converter_on |-> $stable(loop_kp)) else $error("gain moved");
endmodule
bind converter_protection_supervisor supervisor_monitor mon_u (.*);

// ---- bench/power_stage_model.sv ----
// power stage model: switching period boundaries of both phases
`timescale 1ns/1ns
module power_stage_model (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	output logic      period_end_1,
	output logic      period_end_2
);
	logic [3:0] cnt_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) cnt_reg <= 4'h0;
		else cnt_reg <= cnt_reg + 4'h1;
	end
	// phase 1 period ends every 8 clocks, phase 2 every 16 clocks
	assign period_end_1 = cnt_reg[2:0] == 3'h7;
	assign period_end_2 = cnt_reg == 4'hc;
endmodule

// ---- bench/converter_protection_supervisor_tb.sv ----
// self-checking testbench for the converter supervisor
`timescale 1ns/1ns
module converter_protection_supervisor_tb;
	import supervisor_pkg::*;
	localparam int TL = 8;
	logic ref_clk = 0, rst_n = 0, run_request, latching_mode, fault_clear, at_max_freq, current_limiting;
	logic at_min_freq_1, at_min_freq_2, load_jump_1, load_jump_2, period_end_1, period_end_2;
	logic [15:0] vout_ov_limit, dt_slope, vin, vout, vout_target, iout_1, iout_2, ires_1, ires_2;
	logic [15:0] dload_1, dload_2, temp_1, temp_2, fsw_khz_1, fsw_khz_2, loop_kp, loop_ki;
	logic [11:0] dead_time_trim, high_res_pulse_unit_dt_1, high_res_pulse_unit_dt_2;
	logic [9:0]  sync_rectifier_on_time_1, sync_rectifier_on_time_2;
	logic [4:0]  fault_flags;
	logic        converter_on, start_sequence, burst_active, fan_on, sample_tick;
	logic        sync_rectifier_en_1, sync_rectifier_en_2;
	cap_sel_e    cap_sel;
	cap_sel_e    caps[3] = '{CAP_4MF, CAP_6MF, CAP_8MF};
	logic [15:0] kp[3] = '{KP_4MF, KP_6MF, KP_8MF};
	logic [15:0] ki[3] = '{KI_4MF, KI_6MF, KI_8MF};
	int          bad_count = 0, num_checks = 0;
	converter_protection_supervisor #(.RETRY_CYCLES_TICKS(4), .CURLIM_CYCLES_TICKS(4), .TICK_LEN(TL)) dut_u (.*);
	power_stage_model stage_u (.ref_clk(ref_clk), .rst_n(rst_n), .period_end_1(period_end_1),
		.period_end_2(period_end_2));
	always #25 ref_clk = ~ref_clk;
	// ==================== tasks ====================
	task automatic w(input int n);
		repeat (n * TL + 2) @(posedge ref_clk);
	endtask
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic clr;
		fault_clear <= 1'b1;
		@(posedge ref_clk);
		fault_clear <= 1'b0;
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
	// ==================== tests ====================
	initial begin
		{run_request, latching_mode, fault_clear, at_max_freq, current_limiting} = '0;
		{at_min_freq_1, at_min_freq_2, load_jump_1, load_jump_2} = '0;
		{iout_1, iout_2, ires_1, ires_2, dload_1, dload_2} = '0;
		vout_ov_limit = VOUT_OV_DEFAULT;
		dead_time_trim = 12'h020;
		dt_slope = 16'h8000;
		cap_sel = CAP_4MF;
		vin = 16'h9470;
		vout = 16'h12c0;
		vout_target = 16'h12c0;
		temp_1 = 16'h0019;
		temp_2 = 16'h0019;
		fsw_khz_1 = 16'h0100;
		fsw_khz_2 = 16'h0200;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (caps[i]) begin
			cap_sel <= caps[i];
			w(1);
			chk(loop_kp === kp[i] && loop_ki === ki[i], "gain set");
		end
		run_request <= 1'b1;
		w(2);
		chk(converter_on === 1'b1, "no start");
		chk(high_res_pulse_unit_dt_1 === 12'h0a0 && high_res_pulse_unit_dt_2 === 12'h120, "dead time");
		vin <= 16'h86c3;
		w(2);
		chk(converter_on === 1'b0 && fault_flags[F_IN_RANGE] === 1'b1, "low vin ran");
		vin <= 16'ha21d;
		w(2);
		chk(converter_on === 1'b0, "high vin ran");
		vin <= 16'ha21c;
		w(2);
		chk(converter_on === 1'b1, "no resume");
		clr();
		{iout_1, ires_1, dload_1} <= {16'h01c3, 16'h0383, 16'h031f};
		w(2);
		chk(sync_rectifier_en_1 === 1'b1 && sync_rectifier_en_2 === 1'b0
			&& sync_rectifier_on_time_2 === 10'h000, "rectifier gate");
		w(3);
		// five ramp steps after the enabling tick
		chk(sync_rectifier_on_time_1 === ONTIME_START + 5 * ONTIME_STEP, "no ramp");
		load_jump_1 <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(sync_rectifier_en_1 === 1'b0, "jump kept rectifier");
		load_jump_1 <= 1'b0;
		{iout_1, iout_2} <= {16'h0fa0, 16'h0fa0};
		w(2);
		chk(fault_flags[F_OVER_POWER] === 1'b1 && converter_on === 1'b0, "overpower");
		{iout_1, iout_2} <= {16'h01c3, 16'h0000};
		w(7);
		chk(converter_on === 1'b1, "no retry");
		current_limiting <= 1'b1;
		clr();
		w(6);
		chk(fault_flags[F_OVER_POWER] === 1'b1, "limit time");
		current_limiting <= 1'b0;
		latching_mode <= 1'b1;
		w(4);
		chk(converter_on === 1'b1, "no run before ov");
		{vout_ov_limit, vout, vout_target} <= {16'h1388, 16'h1389, 16'h1389};
		w(2);
		chk(fault_flags[F_OUT_OV] === 1'b1 && converter_on === 1'b0, "ov trip");
		{vout_ov_limit, vout, vout_target} <= {VOUT_OV_DEFAULT, 16'h12c0, 16'h12c0};
		w(8);
		chk(converter_on === 1'b0, "latch lost");
		clr();
		w(8);
		chk(converter_on === 1'b1 && sync_rectifier_en_1 === 1'b1, "no restart");
		latching_mode <= 1'b0;
		cap_sel <= CAP_4MF;
		vout <= 16'h1324;
		w(2);
		chk(burst_active === 1'b0, "early burst");
		chk(loop_kp === KP_8MF && loop_ki === KI_8MF, "gain moved while running");
		at_max_freq <= 1'b1;
		w(2);
		chk(burst_active === 1'b1 && sync_rectifier_en_1 === 1'b0, "soft burst");
		{vout, at_max_freq} <= {16'h12c0, 1'b0};
		w(3);
		chk(burst_active === 1'b0 && converter_on === 1'b1, "burst resume");
		vout <= 16'h13ec;
		w(2);
		chk(burst_active === 1'b1 && converter_on === 1'b0, "hard burst");
		vout <= 16'h12c0;
		w(4);
		{at_min_freq_1, at_min_freq_2} <= 2'b11;
		w(40);
		chk(fault_flags[F_OPEN_LOOP] === 1'b0, "open loop early");
		w(12);
		chk(fault_flags[F_OPEN_LOOP] === 1'b1, "open loop");
		{at_min_freq_1, at_min_freq_2} <= 2'b00;
		clr();
		foreach (kp[i]) begin
			temp_2 <= (i == 0) ? 16'h002e : (i == 1) ? 16'h0028 : 16'h0022;
			w(1);
			chk(fan_on === (i < 2), "fan");
		end
		temp_1 <= 16'h0051;
		w(2);
		chk(fault_flags[F_OVER_TEMP] === 1'b1 && converter_on === 1'b0, "overtemp");
		temp_1 <= 16'h0019;
		clr();
		w(7);
		chk(fault_flags[F_OVER_TEMP] === 1'b1 && converter_on === 1'b0, "overtemp cleared");
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(fault_flags === 5'h00 && loop_kp === KP_4MF, "reset values");
		print_verdict();
	end
endmodule
